// file: verilog/pin_mux_defines.svh
// Purpose: Offsets, field positions, reset values and key for the pin mux block
// Assumes: Byte offsets within the configuration block
// Notes: Definitions only
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// ==========================================
// Register offsets
`define SEL_REG_OFS 12'h000
`define GUARD_REG_OFS 12'h018

// ==========================================
// Select register fields
`define SEL_USED_W 7
`define SEL_VIDC_BIT 6
`define SEL_VIDB_BIT 5
`define SEL_VIDA_BIT 4
`define SEL_TWC_BIT 3
`define SEL_SERB_BIT 2
`define SEL_SERA_BIT 1
`define SEL_AUD_BIT 0
`define SEL_RESET 32'h0000_0006

// ==========================================
// Guard register
`define GUARD_KEY 32'h10C0_010C
`define GUARD_RESET 1'b1

// ==========================================
// Software timing
// Cycles a master waits after an enable before touching that peripheral
`define ENABLE_WAIT 128

// ==========================================
// Shared pin groups
`define LOW_GRP_W 7
`define UP_GRP_W 8

`endif

// file: verilog/pin_mux_pkg.sv
// Purpose: Types shared by the pin mux block
// Assumes: Nothing
// Notes: Constants live in the defines header
package pin_mux_pkg;
  typedef logic [31:0] word_t;
  typedef logic [11:0] ofs_t;
endpackage

// file: verilog/pin_share.sv
// Purpose: One group of shared pins between two owner peripherals
// Assumes: Owner outputs and enables on SYS_CLK
// Notes: Pad path is combinational; the pad cell adds no flop
`timescale 1ns/100ps
`default_nettype none
module pin_share #(
  parameter int W = 7
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sel_b,
  input wire logic a_on,
  input wire logic b_on,
  input wire logic [W-1:0] a_out,
  input wire logic [W-1:0] a_oe,
  input wire logic [W-1:0] b_out,
  input wire logic [W-1:0] b_oe,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe,
  output logic [W-1:0] a_in,
  output logic [W-1:0] b_in
);
  logic owner_on;

  always_comb begin
    owner_on = sel_b ? b_on : a_on;
    // Disabled owner leaves the pad floating, the other owner never drives
    pad_oe = owner_on ? (sel_b ? b_oe : a_oe) : '0; // RQ20
    pad_out = sel_b ? b_out : a_out;
    // Deselected owner sees a quiet zero
    a_in = (!sel_b && a_on) ? pad_in : '0;
    b_in = (sel_b && b_on) ? pad_in : '0;
  end

  // ==========================================
  // Checks
  float_off_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ20
    !owner_on |-> pad_oe == '0) else $error("pad driven while owner off");
  exclusive_a: assert property (@(posedge clk) disable iff (!rst_b) // RQ9
    (a_in != '0) |-> (!sel_b && b_in == '0)) else $error("both owners see pad");
endmodule
`default_nettype wire

// file: verilog/pin_mux.sv
// Purpose: Peripheral enables, shared pin selection and guarded config register
// Assumes: Single-cycle register strobes on SYS_CLK
// Notes: Read data appears one cycle after REG_RD
// Function
// RQ1: Select bits 31..7 read zero; writes there are ignored.
// RQ2: Bit 6 enables video port C; clear powers it down; resets clear.
// RQ3: Bit 5 enables video port B; clear powers it down; resets clear.
// RQ4: Bit 4 enables video port A; clear powers it down; resets clear.
// RQ5: Bit 3 enables two-wire controller; clear powers it down; resets clear.
// RQ6: Bit 2 hands port B lower pins to serial B; resets set.
// RQ7: Bit 1 hands port A lower pins to serial A; resets set.
// RQ8: Bit 0 hands both upper pin groups to the audio port.
// RQ9: Video lower data 8..2 shared with paired serial port signals.
// RQ10: Upper data 19..12 of A and B shared with audio signals.
// RQ11: Audio, video ports and two-wire controller come up disabled.
// RQ12: Exact 32-bit key written to guard register unlocks the select register.
// RQ13: Guard register read returns guard flag: 1 locked, 0 unlocked.
// RQ14: Select register changes only while guard flag is zero.
// RQ15: Software should not switch pin sharing at run time.
// RQ16: Software idles a peripheral before disabling it.
// RQ17: Any select register write relocks it.
// RQ18: Masters wait 128 cycles after enabling before access.
// RQ19: Guard flag resets to locked.
// RQ20: Pin with disabled selected owner is undriven.
`include "pin_mux_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module pin_mux (
  input wire logic SYS_CLK,
  input wire logic RST_B,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire pin_mux_pkg::ofs_t REG_ADDR,
  input wire pin_mux_pkg::word_t REG_WDATA,
  output pin_mux_pkg::word_t REG_RDATA,
  output logic VIDEO_PORT_A_ON,
  output logic VIDEO_PORT_B_ON,
  output logic VIDEO_PORT_C_ON,
  output logic TWO_WIRE_CTRL_ON,
  output logic SERIAL_A_ON,
  output logic SERIAL_B_ON,
  output logic AUDIO_ON,
  input wire logic [`LOW_GRP_W-1:0] VIDA_LO_OUT,
  input wire logic [`LOW_GRP_W-1:0] VIDA_LO_OE,
  output logic [`LOW_GRP_W-1:0] VIDA_LO_IN,
  input wire logic [`LOW_GRP_W-1:0] SERA_OUT,
  input wire logic [`LOW_GRP_W-1:0] SERA_OE,
  output logic [`LOW_GRP_W-1:0] SERA_IN,
  input wire logic [`LOW_GRP_W-1:0] PADA_LO_IN,
  output logic [`LOW_GRP_W-1:0] PADA_LO_OUT,
  output logic [`LOW_GRP_W-1:0] PADA_LO_OE,
  input wire logic [`LOW_GRP_W-1:0] VIDB_LO_OUT,
  input wire logic [`LOW_GRP_W-1:0] VIDB_LO_OE,
  output logic [`LOW_GRP_W-1:0] VIDB_LO_IN,
  input wire logic [`LOW_GRP_W-1:0] SERB_OUT,
  input wire logic [`LOW_GRP_W-1:0] SERB_OE,
  output logic [`LOW_GRP_W-1:0] SERB_IN,
  input wire logic [`LOW_GRP_W-1:0] PADB_LO_IN,
  output logic [`LOW_GRP_W-1:0] PADB_LO_OUT,
  output logic [`LOW_GRP_W-1:0] PADB_LO_OE,
  input wire logic [`UP_GRP_W-1:0] VIDA_UP_OUT,
  input wire logic [`UP_GRP_W-1:0] VIDA_UP_OE,
  output logic [`UP_GRP_W-1:0] VIDA_UP_IN,
  input wire logic [`UP_GRP_W-1:0] AUD_CTL_OUT,
  input wire logic [`UP_GRP_W-1:0] AUD_CTL_OE,
  output logic [`UP_GRP_W-1:0] AUD_CTL_IN,
  input wire logic [`UP_GRP_W-1:0] PADA_UP_IN,
  output logic [`UP_GRP_W-1:0] PADA_UP_OUT,
  output logic [`UP_GRP_W-1:0] PADA_UP_OE,
  input wire logic [`UP_GRP_W-1:0] VIDB_UP_OUT,
  input wire logic [`UP_GRP_W-1:0] VIDB_UP_OE,
  output logic [`UP_GRP_W-1:0] VIDB_UP_IN,
  input wire logic [`UP_GRP_W-1:0] AUD_DATA_OUT,
  input wire logic [`UP_GRP_W-1:0] AUD_DATA_OE,
  output logic [`UP_GRP_W-1:0] AUD_DATA_IN,
  input wire logic [`UP_GRP_W-1:0] PADB_UP_IN,
  output logic [`UP_GRP_W-1:0] PADB_UP_OUT,
  output logic [`UP_GRP_W-1:0] PADB_UP_OE
);
  import pin_mux_pkg::*;

  logic [`SEL_USED_W-1:0] sel_q;
  logic [`SEL_USED_W-1:0] sel_d;
  logic guard_q;
  logic guard_d;
  word_t rdata_q;
  word_t rdata_d;
  logic wr_sel;
  logic wr_guard;
  localparam word_t SEL_RST_WORD = `SEL_RESET;

  function automatic word_t sel_word(input logic [`SEL_USED_W-1:0] v);
    sel_word = {{(32 - `SEL_USED_W){1'b0}}, v};
  endfunction

  // ==========================================
  // Register file
  always_comb begin
    wr_sel = REG_WR && (REG_ADDR == `SEL_REG_OFS);
    wr_guard = REG_WR && (REG_ADDR == `GUARD_REG_OFS);
    sel_d = sel_q;
    guard_d = guard_q;
    if (wr_sel) begin
      if (!guard_q) begin
        sel_d = REG_WDATA[`SEL_USED_W-1:0]; // RQ14 RQ1
      end
      guard_d = 1'b1; // RQ17
    end else if (wr_guard) begin
      // Wrong key relocks, so a stray write never leaves it open
      guard_d = (REG_WDATA != `GUARD_KEY); // RQ12
    end
    rdata_d = rdata_q;
    if (REG_RD) begin
      if (REG_ADDR == `SEL_REG_OFS) begin
        rdata_d = sel_word(sel_q); // RQ1
      end else if (REG_ADDR == `GUARD_REG_OFS) begin
        rdata_d = {31'h0000_0000, guard_q}; // RQ13
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_B) begin
      sel_q <= SEL_RST_WORD[`SEL_USED_W-1:0]; // RQ11
      guard_q <= `GUARD_RESET; // RQ19
      rdata_q <= 32'h0000_0000;
    end else begin
      sel_q <= sel_d;
      guard_q <= guard_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================
  // Enables
  always_comb begin
    REG_RDATA = rdata_q;
    VIDEO_PORT_C_ON = sel_q[`SEL_VIDC_BIT]; // RQ2
    VIDEO_PORT_B_ON = sel_q[`SEL_VIDB_BIT]; // RQ3
    VIDEO_PORT_A_ON = sel_q[`SEL_VIDA_BIT]; // RQ4
    TWO_WIRE_CTRL_ON = sel_q[`SEL_TWC_BIT]; // RQ5
    SERIAL_B_ON = sel_q[`SEL_SERB_BIT]; // RQ6
    SERIAL_A_ON = sel_q[`SEL_SERA_BIT]; // RQ7
    AUDIO_ON = sel_q[`SEL_AUD_BIT]; // RQ8
  end

  // ==========================================
  // Shared pin groups
  pin_share #(.W(`LOW_GRP_W)) lo_a ( // RQ9 RQ7
    .clk(SYS_CLK), .rst_b(RST_B), .sel_b(sel_q[`SEL_SERA_BIT]),
    .a_on(sel_q[`SEL_VIDA_BIT]), .b_on(1'b1),
    .a_out(VIDA_LO_OUT), .a_oe(VIDA_LO_OE), .b_out(SERA_OUT), .b_oe(SERA_OE),
    .pad_in(PADA_LO_IN), .pad_out(PADA_LO_OUT), .pad_oe(PADA_LO_OE),
    .a_in(VIDA_LO_IN), .b_in(SERA_IN)
  );
  pin_share #(.W(`LOW_GRP_W)) lo_b ( // RQ9 RQ6
    .clk(SYS_CLK), .rst_b(RST_B), .sel_b(sel_q[`SEL_SERB_BIT]),
    .a_on(sel_q[`SEL_VIDB_BIT]), .b_on(1'b1),
    .a_out(VIDB_LO_OUT), .a_oe(VIDB_LO_OE), .b_out(SERB_OUT), .b_oe(SERB_OE),
    .pad_in(PADB_LO_IN), .pad_out(PADB_LO_OUT), .pad_oe(PADB_LO_OE),
    .a_in(VIDB_LO_IN), .b_in(SERB_IN)
  );
  pin_share #(.W(`UP_GRP_W)) up_a ( // RQ10 RQ8
    .clk(SYS_CLK), .rst_b(RST_B), .sel_b(sel_q[`SEL_AUD_BIT]),
    .a_on(sel_q[`SEL_VIDA_BIT]), .b_on(1'b1),
    .a_out(VIDA_UP_OUT), .a_oe(VIDA_UP_OE), .b_out(AUD_CTL_OUT), .b_oe(AUD_CTL_OE),
    .pad_in(PADA_UP_IN), .pad_out(PADA_UP_OUT), .pad_oe(PADA_UP_OE),
    .a_in(VIDA_UP_IN), .b_in(AUD_CTL_IN)
  );
  pin_share #(.W(`UP_GRP_W)) up_b ( // RQ10 RQ8
    .clk(SYS_CLK), .rst_b(RST_B), .sel_b(sel_q[`SEL_AUD_BIT]),
    .a_on(sel_q[`SEL_VIDB_BIT]), .b_on(1'b1),
    .a_out(VIDB_UP_OUT), .a_oe(VIDB_UP_OE), .b_out(AUD_DATA_OUT), .b_oe(AUD_DATA_OE),
    .pad_in(PADB_UP_IN), .pad_out(PADB_UP_OUT), .pad_oe(PADB_UP_OE),
    .a_in(VIDB_UP_IN), .b_in(AUD_DATA_IN)
  );

  // ==========================================
  // Checks
  reset_state_a: assert property (@(posedge SYS_CLK) // RQ11
    !RST_B |=> (sel_word(sel_q) == `SEL_RESET && guard_q)) else $error("bad reset state");
  key_unlock_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ12
    wr_guard && REG_WDATA == `GUARD_KEY |=> !guard_q) else $error("key did not unlock");
  bad_key_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ12
    wr_guard && REG_WDATA != `GUARD_KEY |=> guard_q) else $error("wrong key unlocked");
  guard_read_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ13
    REG_RD && REG_ADDR == `GUARD_REG_OFS |=> REG_RDATA == {31'h0, $past(guard_q)})
    else $error("guard read wrong");
  locked_hold_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ14
    wr_sel && guard_q |=> $stable(sel_q)) else $error("locked write changed select");
  open_write_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ14
    wr_sel && !guard_q |=> sel_q == $past(REG_WDATA[`SEL_USED_W-1:0]))
    else $error("unlocked write lost");
  relock_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ17
    wr_sel |=> guard_q) else $error("no relock");
  reserved_read_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ1
    REG_RD && REG_ADDR == `SEL_REG_OFS |=> REG_RDATA[31:`SEL_USED_W] == '0)
    else $error("reserved bits not zero");
  enable_track_a: assert property (@(posedge SYS_CLK) disable iff (!RST_B) // RQ3
    wr_sel && !guard_q ##1 1'b1 |-> VIDEO_PORT_B_ON == $past(REG_WDATA[`SEL_VIDB_BIT]))
    else $error("port enable mismatch");

  unlock_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B)
    wr_guard && REG_WDATA == `GUARD_KEY ##1 wr_sel && !guard_q);
  locked_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B) wr_sel && guard_q);
  audio_c: cover property (@(posedge SYS_CLK) disable iff (!RST_B) AUDIO_ON && VIDEO_PORT_A_ON);
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Purpose: Self-checking bench for the peripheral select and pin sharing block
// Assumes: One-cycle register strobes, read data one cycle after the read strobe
// Notes: Read results are queued by the driver and checked by a watcher process
`include "pin_mux_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import pin_mux_pkg::*;
  logic SYS_CLK, RST_B, REG_WR, REG_RD, rd_seen;
  ofs_t REG_ADDR;
  word_t REG_WDATA, REG_RDATA, sel, v;
  word_t exp_q[$];
  logic VIDEO_PORT_A_ON, VIDEO_PORT_B_ON, VIDEO_PORT_C_ON, TWO_WIRE_CTRL_ON;
  logic SERIAL_A_ON, SERIAL_B_ON, AUDIO_ON;
  logic [6:0] VIDA_LO_OUT, VIDA_LO_OE, VIDA_LO_IN, SERA_OUT, SERA_OE, SERA_IN;
  logic [6:0] PADA_LO_IN, PADA_LO_OUT, PADA_LO_OE, VIDB_LO_OUT, VIDB_LO_OE, VIDB_LO_IN;
  logic [6:0] SERB_OUT, SERB_OE, SERB_IN, PADB_LO_IN, PADB_LO_OUT, PADB_LO_OE;
  logic [7:0] VIDA_UP_OUT, VIDA_UP_OE, VIDA_UP_IN, AUD_CTL_OUT, AUD_CTL_OE, AUD_CTL_IN;
  logic [7:0] PADA_UP_IN, PADA_UP_OUT, PADA_UP_OE, VIDB_UP_OUT, VIDB_UP_OE, VIDB_UP_IN;
  logic [7:0] AUD_DATA_OUT, AUD_DATA_OE, AUD_DATA_IN, PADB_UP_IN, PADB_UP_OUT, PADB_UP_OE;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;

  pin_mux u_pin_mux (.*);

  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end

  // ==========
  // Shared tasks
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask

  task automatic op(input logic w, input logic r, input ofs_t a, input word_t d);
    @(posedge SYS_CLK);
    REG_WR <= w;
    REG_RD <= r;
    REG_ADDR <= a;
    REG_WDATA <= d;
  endtask

  task automatic rd(input ofs_t a, input word_t e);
    exp_q.push_back(e);
    op(1'b0, 1'b1, a, '0);
    // One-cycle strobe: a held strobe reads again with no note queued
    op(1'b0, 1'b0, a, '0);
  endtask

  // Owners stop driving before their enables or pin owners change
  task automatic quiet;
    @(posedge SYS_CLK);
    {VIDA_LO_OE, SERA_OE, VIDB_LO_OE, SERB_OE, VIDA_UP_OE, AUD_CTL_OE, VIDB_UP_OE,
     AUD_DATA_OE} <= '0;
    @(negedge SYS_CLK);
    chk("idle pads", {PADA_LO_OE, PADB_LO_OE, PADA_UP_OE, PADB_UP_OE}, 32'h0000_0000);
  endtask

  task automatic chk_on;
    @(negedge SYS_CLK);
    chk("enables", {VIDEO_PORT_C_ON, VIDEO_PORT_B_ON, VIDEO_PORT_A_ON, TWO_WIRE_CTRL_ON,
        SERIAL_B_ON, SERIAL_A_ON, AUDIO_ON}, sel[6:0]);
  endtask

  // Deselected or powered-down owners must see zero and never drive
  task automatic grp(input string n, input logic alt, input logic vid_on,
      input logic [7:0] vo, voe, ao, aoe, pin, pout, poe, vin, ain);
    logic [7:0] eoe;
    eoe = alt ? aoe : (vid_on ? voe : 8'h00);
    chk({n, " oe"}, poe, eoe);
    chk({n, " out"}, pout & eoe, (alt ? ao : vo) & eoe);
    chk({n, " video in"}, vin, (!alt && vid_on) ? pin : 8'h00);
    chk({n, " alt in"}, ain, alt ? pin : 8'h00);
  endtask

  task automatic pins;
    logic [159:0] r;
    r = {$urandom, $urandom, $urandom, $urandom, $urandom};
    @(posedge SYS_CLK);
    {VIDA_LO_OUT, VIDA_LO_OE, SERA_OUT, SERA_OE, PADA_LO_IN, VIDB_LO_OUT, VIDB_LO_OE,
     SERB_OUT, SERB_OE, PADB_LO_IN, VIDA_UP_OUT, VIDA_UP_OE, AUD_CTL_OUT, AUD_CTL_OE,
     PADA_UP_IN, VIDB_UP_OUT, VIDB_UP_OE, AUD_DATA_OUT, AUD_DATA_OE, PADB_UP_IN} <= r[149:0];
    @(negedge SYS_CLK);
    grp("a lo", sel[1], sel[4], VIDA_LO_OUT, VIDA_LO_OE, SERA_OUT, SERA_OE, PADA_LO_IN,
        PADA_LO_OUT, PADA_LO_OE, VIDA_LO_IN, SERA_IN);
    grp("b lo", sel[2], sel[5], VIDB_LO_OUT, VIDB_LO_OE, SERB_OUT, SERB_OE, PADB_LO_IN,
        PADB_LO_OUT, PADB_LO_OE, VIDB_LO_IN, SERB_IN);
    grp("a up", sel[0], sel[4], VIDA_UP_OUT, VIDA_UP_OE, AUD_CTL_OUT, AUD_CTL_OE, PADA_UP_IN,
        PADA_UP_OUT, PADA_UP_OE, VIDA_UP_IN, AUD_CTL_IN);
    grp("b up", sel[0], sel[5], VIDB_UP_OUT, VIDB_UP_OE, AUD_DATA_OUT, AUD_DATA_OE, PADB_UP_IN,
        PADB_UP_OUT, PADB_UP_OE, VIDB_UP_IN, AUD_DATA_IN);
  endtask

  task automatic finish_test;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ==========
  // Read watcher and hang guard
  always @(posedge SYS_CLK) rd_seen <= REG_RD;

  always @(negedge SYS_CLK) begin
    if (rd_seen === 1'b1 && exp_q.size() > 0) chk("rdata", REG_RDATA, exp_q.pop_front());
  end

  always @(posedge SYS_CLK) begin
    cycles++;
    // Loop of 128 codes with a 128-cycle settle each needs about 18000 cycles
    if (cycles == 40000) begin
      failures++;
      finish_test();
    end
  end

  // ==========
  // Main sequence
  initial begin
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, rd_seen, RST_B} = '0;
    {VIDA_LO_OUT, VIDA_LO_OE, SERA_OUT, SERA_OE, PADA_LO_IN, VIDB_LO_OUT, VIDB_LO_OE,
     SERB_OUT, SERB_OE, PADB_LO_IN, VIDA_UP_OUT, VIDA_UP_OE, AUD_CTL_OUT, AUD_CTL_OE,
     PADA_UP_IN, VIDB_UP_OUT, VIDB_UP_OE, AUD_DATA_OUT, AUD_DATA_OE, PADB_UP_IN} = '0;
    void'($urandom(32'h956d8e98));
    sel = `SEL_RESET;
    repeat (6) @(posedge SYS_CLK);
    RST_B <= 1'b1;
    chk_on();
    rd(`SEL_REG_OFS, `SEL_RESET);
    rd(`GUARD_REG_OFS, 32'h0000_0001);
    pins();
    $display("test reset done");
    op(1'b1, 1'b0, `SEL_REG_OFS, 32'hFFFF_FFFF);
    op(1'b1, 1'b0, `GUARD_REG_OFS, `GUARD_KEY ^ 32'h0000_0001);
    op(1'b1, 1'b0, `SEL_REG_OFS, 32'hFFFF_FFFF);
    op(1'b0, 1'b0, '0, '0);
    chk_on();
    rd(`SEL_REG_OFS, sel);
    op(1'b1, 1'b0, `GUARD_REG_OFS, `GUARD_KEY);
    rd(`GUARD_REG_OFS, 32'h0000_0000);
    rd(12'h004, 32'h0000_0000);
    $display("test guard done");
    // Every select code, back-to-back key and select writes, junk in the reserved bits
    for (int i = 0; i < 128; i++) begin
      v = ($urandom & 32'hFFFF_FF80) | i;
      quiet();
      op(1'b1, 1'b0, `GUARD_REG_OFS, `GUARD_KEY);
      op(1'b1, 1'b0, `SEL_REG_OFS, v);
      op(1'b1, 1'b0, `SEL_REG_OFS, ~v);
      sel = v & 32'h0000_007F;
      rd(`GUARD_REG_OFS, 32'h0000_0001);
      chk_on();
      rd(`SEL_REG_OFS, sel);
      repeat (`ENABLE_WAIT) @(posedge SYS_CLK);
      pins();
      pins();
    end
    $display("test codes done");
    @(posedge SYS_CLK);
    RST_B <= 1'b0;
    @(posedge SYS_CLK);
    RST_B <= 1'b1;
    sel = `SEL_RESET;
    chk_on();
    rd(`GUARD_REG_OFS, 32'h0000_0001);
    pins();
    repeat (4) op(1'b0, 1'b0, '0, '0);
    $display("test second reset done");
    finish_test();
  end
endmodule
`default_nettype wire
